/* File: hdl/irq_selector_defines.vh */
`ifndef IRQ_SELECTOR_DEFINES_VH
`define IRQ_SELECTOR_DEFINES_VH

// register byte addresses (the full 32-bit address is decoded)
`define ADDR_SELECT_HIGH 32'h019C0000
`define ADDR_SELECT_LOW 32'h019C0004
`define ADDR_EXT_POLARITY 32'h019C0008
`define ADDR_IRQ_STATUS 32'h019C000C
`define ADDR_IRQ_ENABLE 32'h019C0010
`define ADDR_IRQ_CLEAR 32'h019C0014
`define ADDR_GLOBAL_ENABLE 32'h019C0018

// reset values of the selector registers
`define RST_SELECT_LOW 32'h250718A4
`define RST_SELECT_HIGH 32'h08202D43

// field positions inside a selector register
`define FLD0_LSB 0
`define FLD1_LSB 5
`define FLD2_LSB 10
`define FLD3_LSB 16
`define FLD4_LSB 21
`define FLD5_LSB 26
`define SEL_W 5
`define SEL_MASK 32'h7FFF7FFF

// selector codes
`define CODE_NONE 5'h00
`define CODE_TIMER0 5'h01
`define CODE_TIMER1 5'h02
`define CODE_MEMIF 5'h03
`define CODE_GPIO4 5'h04
`define CODE_GPIO5 5'h05
`define CODE_GPIO6 5'h06
`define CODE_GPIO7 5'h07
`define CODE_DMA 5'h08
`define CODE_EMU_XFER 5'h09
`define CODE_EMU_RX 5'h0A
`define CODE_EMU_TX 5'h0B
`define CODE_SER0_TX 5'h0C
`define CODE_SER0_RX 5'h0D
`define CODE_SER1_TX 5'h0E
`define CODE_SER1_RX 5'h0F
`define CODE_GPIO0 5'h10

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: hdl/pin_edge_detect.v */
`timescale 1ns/1ps
`include "irq_selector_defines.vh"

// synchronises external interrupt pins and pulses on the chosen edge
module pin_edge_detect #(
  parameter N = 4
) (
  input wire clk,
  input wire rst_n,
  input wire [N-1:0] pin,
  input wire [N-1:0] polarity,
  output wire [N-1:0] edge_pulse
);
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_pin
      reg meta_r;
      reg sync_r;
      reg last_r;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          last_r <= 1'b0;
        end else begin
          meta_r <= pin[i];
          sync_r <= meta_r;
          last_r <= sync_r;
        end
      end
      // polarity 0 rising, 1 falling
      assign edge_pulse[i] = polarity[i] ? (last_r & ~sync_r) : (~last_r & sync_r);
    end
  endgenerate
endmodule // pin_edge_detect

/* File: hdl/interrupt_source_selector.v */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "irq_selector_defines.vh"

module interrupt_source_selector (
  input wire clk,
  input wire rst_n,
  // axi4-lite slave
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // event sources, on clk
  input wire timer0_event,
  input wire timer1_event,
  input wire memory_interface_event,
  input wire dma_completion_event,
  input wire emulation_transfer_event,
  input wire emulation_receive_event,
  input wire emulation_transmit_event,
  input wire serial0_transmit_event,
  input wire serial0_receive_event,
  input wire serial1_transmit_event,
  input wire serial1_receive_event,
  input wire gpio_event_0,
  // device pins and core-side levels
  input wire [3:0] external_interrupt_pin,
  input wire nmi_n,
  // core interrupt inputs
  output reg [15:0] core_irq,
  output reg [15:0] core_irq_top,
  output reg irq_out
);
  reg [31:0] interrupt_select_high_r;
  reg [31:0] interrupt_select_low_r;
  reg [3:0] external_interrupt_polarity_r;
  reg global_interrupt_enable_r;
  reg [15:0] status_r;
  reg [15:0] enable_r;
  reg [15:0] status_nxt;
  reg nmi_meta_r;
  reg nmi_sync_r;
  reg rst_seen_r;
  reg [31:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg aw_held_r;
  reg w_held_r;
  reg [15:0] clr_pulse;
  reg [31:0] rd_val;
  reg rd_ok;
  reg wr_ok;
  reg [15:0] line;
  reg [15:0] top_nxt;
  integer k;
  integer m;

  wire [3:0] gpio_edge;
  wire [31:0] wr_merged;
  wire [16:0] src;
  wire do_write;

  // gpio events 4-7 from pin edges
  pin_edge_detect #(.N(4)) u_edges (
    .clk(clk),
    .rst_n(rst_n),
    .pin(external_interrupt_pin),
    .polarity(external_interrupt_polarity_r),
    .edge_pulse(gpio_edge)
  );

  // source vector indexed by selector code; index 0 is the empty source
  assign src = {gpio_event_0, serial1_receive_event, serial1_transmit_event,
                serial0_receive_event, serial0_transmit_event,
                emulation_transmit_event, emulation_receive_event,
                emulation_transfer_event, dma_completion_event,
                gpio_edge, memory_interface_event, timer1_event,
                timer0_event, 1'b0};

  function [4:0] field;
    input [31:0] r;
    input [2:0] n;
    begin
      case (n)
        3'd0: field = r[`FLD0_LSB +: `SEL_W];
        3'd1: field = r[`FLD1_LSB +: `SEL_W];
        3'd2: field = r[`FLD2_LSB +: `SEL_W];
        3'd3: field = r[`FLD3_LSB +: `SEL_W];
        3'd4: field = r[`FLD4_LSB +: `SEL_W];
        default: field = r[`FLD5_LSB +: `SEL_W];
      endcase
    end
  endfunction

  function pick;
    input [16:0] s;
    input [4:0] code;
    begin
      // codes above the last source select nothing
      if (code > `CODE_GPIO0) begin
        pick = 1'b0;
      end else begin
        pick = s[code];
      end
    end
  endfunction

  // nmi pin synchroniser
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_meta_r <= 1'b0;
      nmi_sync_r <= 1'b0;
      rst_seen_r <= 1'b1;
    end else begin
      nmi_meta_r <= ~nmi_n;
      nmi_sync_r <= nmi_meta_r;
      rst_seen_r <= 1'b0;
    end
  end

  // raw lines before the global gate
  always @* begin
    line = 16'h0000;
    line[0] = rst_seen_r;
    line[1] = nmi_sync_r;
    for (k = 0; k < 6; k = k + 1) begin
      line[4 + k] = pick(src, field(interrupt_select_low_r, k[2:0]));
      line[10 + k] = pick(src, field(interrupt_select_high_r, k[2:0]));
    end
  end

  // status: set wins over a same-cycle clear
  always @* begin
    status_nxt = (status_r & ~clr_pulse) | line;
  end

  // highest priority gated pending line
  always @* begin
    top_nxt = 16'h0000;
    for (m = 15; m >= 0; m = m - 1) begin
      if (core_irq_nxt_bit(m)) begin
        top_nxt = 16'h0001 << m;
      end
    end
  end

  function core_irq_nxt_bit;
    input integer b;
    begin
      if (b < 4) begin
        core_irq_nxt_bit = line[b];
      end else begin
        core_irq_nxt_bit = line[b] & global_interrupt_enable_r;
      end
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_irq <= 16'h0000;
      core_irq_top <= 16'h0000;
      irq_out <= 1'b0;
      status_r <= 16'h0000;
    end else begin
      core_irq <= {line[15:4] & {12{global_interrupt_enable_r}}, 2'b00, line[1:0]};
      core_irq_top <= top_nxt;
      status_r <= status_nxt;
      irq_out <= |(status_nxt & enable_r);
    end
  end

  // axi4-lite write path
  assign do_write = (aw_held_r | (s_axi_awvalid & s_axi_awready))
                  & (w_held_r | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
  wire [31:0] cur_awaddr = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] cur_wdata = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] cur_wstrb = w_held_r ? wstrb_r : s_axi_wstrb;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer j;
    begin
      for (j = 0; j < 4; j = j + 1) begin
        merge[j*8 +: 8] = s[j] ? d[j*8 +: 8] : old[j*8 +: 8];
      end
    end
  endfunction

  reg [31:0] wr_old;
  always @* begin
    wr_ok = 1'b1;
    wr_old = 32'h00000000;
    clr_pulse = 16'h0000;
    case (cur_awaddr)
      `ADDR_SELECT_HIGH: wr_old = interrupt_select_high_r;
      `ADDR_SELECT_LOW: wr_old = interrupt_select_low_r;
      `ADDR_EXT_POLARITY: wr_old = {28'h0000000, external_interrupt_polarity_r};
      `ADDR_IRQ_ENABLE: wr_old = {16'h0000, enable_r};
      `ADDR_GLOBAL_ENABLE: wr_old = {31'h00000000, global_interrupt_enable_r};
      `ADDR_IRQ_CLEAR: wr_old = 32'h00000000;
      default: wr_ok = 1'b0;
    endcase
    if (do_write && cur_awaddr == `ADDR_IRQ_CLEAR) begin
      clr_pulse = {cur_wstrb[1] ? cur_wdata[15:8] : 8'h00, cur_wstrb[0] ? cur_wdata[7:0] : 8'h00};
    end
  end
  assign wr_merged = merge(wr_old, cur_wdata, cur_wstrb);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      interrupt_select_high_r <= `RST_SELECT_HIGH;
      interrupt_select_low_r <= `RST_SELECT_LOW;
      external_interrupt_polarity_r <= 4'h0;
      enable_r <= 16'h0000;
      global_interrupt_enable_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        case (cur_awaddr)
          `ADDR_SELECT_HIGH: interrupt_select_high_r <= wr_merged & `SEL_MASK;
          `ADDR_SELECT_LOW: interrupt_select_low_r <= wr_merged & `SEL_MASK;
          `ADDR_EXT_POLARITY: external_interrupt_polarity_r <= wr_merged[3:0];
          `ADDR_IRQ_ENABLE: enable_r <= wr_merged[15:0];
          `ADDR_GLOBAL_ENABLE: global_interrupt_enable_r <= wr_merged[0];
          default: ;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi4-lite read path
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `ADDR_SELECT_HIGH: rd_val = interrupt_select_high_r;
      `ADDR_SELECT_LOW: rd_val = interrupt_select_low_r;
      `ADDR_EXT_POLARITY: rd_val = {28'h0000000, external_interrupt_polarity_r};
      `ADDR_IRQ_STATUS: rd_val = {16'h0000, status_r};
      `ADDR_IRQ_ENABLE: rd_val = {16'h0000, enable_r};
      `ADDR_IRQ_CLEAR: rd_val = 32'h00000000;
      `ADDR_GLOBAL_ENABLE: rd_val = {31'h00000000, global_interrupt_enable_r};
      default: begin
        rd_val = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
  // software must enable pins 4-7 as inputs in the gpio block first
endmodule // interrupt_source_selector

/* File: testbench/irq_selector_props.sv */
`timescale 1ns/1ps
module irq_selector_checker (
  input wire clk,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire nmi_n,
  input wire [15:0] core_irq,
  input wire [15:0] core_irq_top
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // seven word slots from the block base, the eighth is a hole
  wire ar_mapped = ((s_axi_araddr & 32'hFFFFFFE3) == 32'h019C0000) && (s_axi_araddr[4:2] != 3'h7);

  fixed_lines_a: assert property (core_irq[3:2] == 2'h0)
    else $error("reserved core line high");
  reset_line_a: assert property ($rose(rst_n) |=> core_irq[0] ##1 !core_irq[0])
    else $error("reset line not a single pulse");
  nmi_set_a: assert property ((!nmi_n)[*5] |-> core_irq[1])
    else $error("nmi line missing");
  nmi_clear_a: assert property (nmi_n[*5] |-> !core_irq[1])
    else $error("nmi line stuck");
  // lines and pick are registered from the same cycle, so they agree in every cycle
  top_pick_a: assert property (core_irq_top == (core_irq & (~core_irq + 16'h0001)))
    else $error("top priority pick wrong");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && !ar_mapped |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule // irq_selector_checker

bind interrupt_source_selector irq_selector_checker checker_inst (.clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .nmi_n(nmi_n), .core_irq(core_irq), .core_irq_top(core_irq_top));

/* File: testbench/event_source_model.sv */
`timescale 1ns/1ps
module event_source_model (
  input wire clk,
  input wire rst_n,
  input wire [11:0] req_evt,
  input wire [3:0] req_pin,
  output reg [11:0] evt,
  output reg [3:0] pin
);
  // sources change just after the edge, as registered peripherals do
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt <= 12'h000;
      pin <= 4'h0;
    end else begin
      evt <= req_evt;
      // pins arrive as enabled gpio inputs, so they reach the block unchanged
      pin <= req_pin;
    end
  end
endmodule // event_source_model

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`include "irq_selector_defines.vh"
module testbench;
  reg clk, rst_n, nmi_n, awvalid, wvalid, bready, arvalid, rready;
  reg [31:0] awaddr, wdata, araddr, lo, hi, rd;
  reg [3:0] wstrb, req_pin;
  reg [11:0] req_evt;
  reg [15:0] lfsr;
  reg [1:0] rsp;
  wire awready, wready, bvalid, arready, rvalid, irq_out;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] core_irq, core_irq_top;
  wire [11:0] evt;
  wire [3:0] pin;
  integer error_cnt, comparisons, i;

  interrupt_source_selector interrupt_source_selector_inst (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer0_event(evt[0]), .timer1_event(evt[1]), .memory_interface_event(evt[2]),
    .dma_completion_event(evt[3]), .emulation_transfer_event(evt[4]),
    .emulation_receive_event(evt[5]), .emulation_transmit_event(evt[6]),
    .serial0_transmit_event(evt[7]), .serial0_receive_event(evt[8]),
    .serial1_transmit_event(evt[9]), .serial1_receive_event(evt[10]), .gpio_event_0(evt[11]),
    .external_interrupt_pin(pin), .nmi_n(nmi_n), .core_irq(core_irq),
    .core_irq_top(core_irq_top), .irq_out(irq_out));
  event_source_model event_source_model_inst (.clk(clk), .rst_n(rst_n), .req_evt(req_evt),
    .req_pin(req_pin), .evt(evt), .pin(pin));

  function src(input [4:0] c, input [11:0] e);
    begin
      if (c >= 5'h01 && c <= 5'h03) src = e[c - 5'h01];
      else if (c >= 5'h08 && c <= 5'h0F) src = e[c - 5'h05];
      else if (c == 5'h10) src = e[11];
      else src = 1'b0; // pin codes stay low while pins are still
    end
  endfunction
  function [15:0] exp_lines(input [31:0] l, input [31:0] h, input [11:0] e);
    integer k;
    reg [31:0] r;
    begin
      exp_lines = 16'h0000;
      for (k = 0; k < 12; k = k + 1) begin
        r = ((k < 6) ? l : h) >> (5 * (k % 6) + ((k % 6) > 2));
        exp_lines[k + 4] = src(r[4:0], e);
      end
    end
  endfunction
  function [15:0] lfsr_next(input [15:0] v);
    lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task axi_write(input [31:0] a, input [31:0] d, input [3:0] s);
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge clk);
      while (!(bvalid && bready)) begin
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        @(posedge clk);
      end
      rsp = bresp;
      bready <= 1'b0;
    end
  endtask
  task axi_read(input [31:0] a);
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      @(posedge clk);
      while (!(rvalid && rready)) begin
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) rready <= 1'b1; // late ready keeps the answer standing a cycle
        @(posedge clk);
      end
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
    end
  endtask
  task apply_reset;
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      cyc(5);
      rst_n <= 1'b1;
    end
  endtask
  task final_report;
    begin
      if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    cyc(20000);
    error_cnt = error_cnt + 1;
    final_report;
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, araddr} = 0;
    {req_evt, req_pin, wstrb} = 0;
    nmi_n = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    lfsr = 16'hDD15;
    apply_reset;
    axi_read(`ADDR_SELECT_LOW);
    chk(rd, `RST_SELECT_LOW);
    axi_read(`ADDR_SELECT_HIGH);
    chk(rd, `RST_SELECT_HIGH);
    axi_read(32'h019C001C);
    chk({rd[31:2], rsp}, {30'h0, `RESP_SLVERR});
    axi_write(32'h019C0020, 32'hFFFFFFFF, 4'hF);
    chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    req_evt <= 12'hFFF;
    cyc(3);
    chk({16'h0, core_irq}, 32'h0);
    axi_write(`ADDR_GLOBAL_ENABLE, 32'h1, 4'hF);
    cyc(3);
    chk({16'h0, core_irq}, {16'h0, exp_lines(`RST_SELECT_LOW, `RST_SELECT_HIGH, 12'hFFF)});
    for (i = 0; i < 24; i = i + 1) begin
      lfsr = lfsr_next(lfsr);
      lo[15:0] = lfsr;
      lfsr = lfsr_next(lfsr);
      lo[31:16] = lfsr;
      lfsr = lfsr_next(lfsr);
      hi = {lfsr, lo[15:0] ^ lfsr};
      if (i == 0) {lo, hi} = {64{1'b1}}; // every field reserved
      if (i == 1) {lo, hi} = {2{32'h42104210}}; // every field picks gpio_event_0
      axi_write(`ADDR_SELECT_LOW, lo, 4'hF);
      axi_write(`ADDR_SELECT_HIGH, hi, 4'hF);
      lfsr = lfsr_next(lfsr);
      req_evt <= lfsr[11:0];
      cyc(3);
      chk({16'h0, core_irq}, {16'h0, exp_lines(lo, hi, lfsr[11:0])});
      chk({16'h0, core_irq_top}, {16'h0, exp_lines(lo, hi, lfsr[11:0]) & (~exp_lines(lo, hi, lfsr[11:0]) + 16'h1)});
      axi_read(`ADDR_SELECT_LOW);
      chk(rd, lo & `SEL_MASK);
      axi_read(`ADDR_SELECT_HIGH);
      chk(rd, hi & `SEL_MASK);
    end
    axi_write(`ADDR_SELECT_HIGH, `RST_SELECT_HIGH, 4'hF);
    axi_write(`ADDR_SELECT_LOW, 32'h0, 4'h1);
    axi_read(`ADDR_SELECT_LOW);
    chk(rd, lo & `SEL_MASK & 32'hFFFFFF00);
    axi_write(`ADDR_SELECT_LOW, `RST_SELECT_LOW, 4'hF);
    req_evt <= 12'h000;
    cyc(3);
    axi_write(`ADDR_IRQ_CLEAR, 32'hFFFF, 4'hF);
    req_evt <= 12'h001;
    cyc(1);
    req_evt <= 12'h000;
    cyc(3);
    axi_read(`ADDR_IRQ_STATUS);
    chk(rd, 32'h4000);
    chk({31'h0, irq_out}, 32'h0);
    axi_write(`ADDR_IRQ_ENABLE, 32'h4000, 4'hF);
    cyc(3);
    chk({31'h0, irq_out}, 32'h1);
    axi_write(`ADDR_IRQ_CLEAR, 32'h4000, 4'hF);
    cyc(3);
    chk({31'h0, irq_out}, 32'h0);
    for (i = 0; i < 2; i = i + 1) begin
      req_pin <= {4{i[0]}};
      cyc(8);
      axi_write(`ADDR_EXT_POLARITY, {28'h0, {4{i[0]}}}, 4'hF);
      axi_write(`ADDR_IRQ_CLEAR, 32'hFFFF, 4'hF);
      req_pin <= {4{~i[0]}};
      cyc(8);
      axi_read(`ADDR_IRQ_STATUS);
      chk(rd, 32'h00F0);
      axi_write(`ADDR_IRQ_CLEAR, 32'hFFFF, 4'hF);
      req_pin <= {4{i[0]}};
      cyc(8);
      axi_read(`ADDR_IRQ_STATUS);
      chk(rd, 32'h0);
    end
    nmi_n <= 1'b0;
    cyc(6);
    chk({31'h0, core_irq[1]}, 32'h1);
    nmi_n <= 1'b1;
    cyc(6);
    apply_reset;
    axi_read(`ADDR_GLOBAL_ENABLE);
    chk(rd, 32'h0);
    final_report;
  end
endmodule // testbench
